// ---- hdl/cpu_memory_glue_waits_regs.svh ----
// register offsets, field positions, reset values and access-time thresholds
`ifndef CPU_MEMORY_GLUE_WAITS_REGS_SVH
`define CPU_MEMORY_GLUE_WAITS_REGS_SVH

`define CTRL_OFFSET       8'h00
`define CMD_OFFSET        8'h04
`define STATUS_OFFSET     8'h08

`define CTRL_ROM_NS_LSB   0
`define CTRL_RAM_NS_LSB   8
`define CTRL_FETCH_EN_BIT 16
`define CTRL_REMAP_BIT    17

`define CMD_ADDR_LSB      0
`define CMD_DATA_LSB      16
`define CMD_KIND_LSB      24

`define STATUS_BUSY_BIT   0
`define STATUS_KIND_LSB   4
`define STATUS_RDATA_LSB  8
`define STATUS_STATE_LSB  16

`define ROM_NS_RESET      8'hAA
`define RAM_NS_RESET      8'h96

`define ZERO_WAIT_NS      8'h55
`define ONE_WAIT_NS       8'hAA
`define TWO_WAIT_NS       8'hC8

`endif

// ---- hdl/glue_pkg.sv ----
// types shared by the memory bus cycle generator
package glue_pkg;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_T1   = 3'b001,
        BUS_T2   = 3'b010,
        BUS_TW   = 3'b011,
        BUS_T3   = 3'b100
    } bus_state_type;

    typedef enum logic [2:0] {
        CYC_FETCH     = 3'b000,
        CYC_MEM_READ  = 3'b001,
        CYC_MEM_WRITE = 3'b010,
        CYC_IO_READ   = 3'b011,
        CYC_IO_WRITE  = 3'b100,
        CYC_INT_ACK   = 3'b101,
        CYC_RET_FETCH = 3'b110
    } cycle_type;

    typedef struct packed {
        bus_state_type st;
        logic          half;
        logic [1:0]    waits_left;
        cycle_type     kind;
        logic [15:0]   addr;
        logic [7:0]    wdata;
        logic [7:0]    rdata;
        logic          busy;
        logic [7:0]    rom_ns;
        logic [7:0]    ram_ns;
        logic          fetch_en;
        logic          remap;
        logic          wr_pend;
        logic [7:0]    wr_sel;
        logic [31:0]   hrdata;
        logic          system_clock_phase;
        logic          memory_request_n_n;
        logic          io_request_n_n;
        logic          rd_n;
        logic          wr_n;
        logic          m1_n;
        logic          data_oe;
    } glue_state_type;

endpackage

// ---- hdl/cpu_memory_glue_waits.sv ----
// processor memory bus cycle generator with access-time driven wait insertion
`include "cpu_memory_glue_waits_regs.svh"

module cpu_memory_glue_waits
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset,
    input  wire logic                   i_hsel,
    input  wire logic [31:0]            i_haddr,
    input  wire logic [1:0]             i_htrans,
    input  wire logic                   i_hwrite,
    input  wire logic [2:0]             i_hsize,
    input  wire logic [31:0]            i_hwdata,
    input  wire logic                   i_hready,
    output logic                        o_hreadyout,
    output logic                        o_hresp,
    output logic [31:0]                 o_hrdata,
    output logic                        o_system_clock_phase,
    output logic [15:0]                 o_addr,
    output logic [7:0]                  o_data,
    output logic                        o_data_oe,
    input  wire logic [7:0]             i_data,
    output logic                        o_memory_request_n,
    output logic                        o_io_request_n,
    output logic                        o_read_n,
    output logic                        o_write_n,
    output logic                        o_fetch_indicator_n,
    output glue_pkg::bus_state_type     o_bus_state
);
    import glue_pkg::*;

    glue_state_type s;
    glue_state_type next_s;

    // --------------------------------------------------------------
    // wait count from memory access time
    // --------------------------------------------------------------
    function automatic logic [1:0] waits_for(input logic [7:0] ns);
        logic [1:0] w;
        w = 2'h3;
        if (ns <= `ZERO_WAIT_NS)
            w = 2'h0;
        else if (ns <= `ONE_WAIT_NS)
            w = 2'h1;
        else if (ns <= `TWO_WAIT_NS)
            w = 2'h2;
        return w;
    endfunction

    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    // control: rom access ns, ram access ns, fetch-only waits, remap
    // command: a write launches one bus cycle of address, data and kind
    // status: busy, kind, last read data, bus state

    // --------------------------------------------------------------
    // cycle kind decode, shared by wait choice, capture and strobes
    // --------------------------------------------------------------
    // opcode fetch, including the fetch that returns from an interrupt
    function automatic logic is_fetch_kind(input cycle_type k);
        logic r;
        r = (k == CYC_FETCH) || (k == CYC_RET_FETCH);
        return r;
    endfunction

    // any cycle that reads memory
    function automatic logic is_read_kind(input cycle_type k);
        logic r;
        r = is_fetch_kind(k) || (k == CYC_MEM_READ);
        return r;
    endfunction

    // any cycle that raises the memory request
    function automatic logic is_mem_kind(input cycle_type k);
        logic r;
        r = is_read_kind(k) || (k == CYC_MEM_WRITE);
        return r;
    endfunction

    // io read or io write
    function automatic logic is_io_kind(input cycle_type k);
        logic r;
        r = (k == CYC_IO_READ) || (k == CYC_IO_WRITE);
        return r;
    endfunction

    // any cycle that drives write data
    function automatic logic is_write_kind(input cycle_type k);
        logic r;
        r = (k == CYC_MEM_WRITE) || (k == CYC_IO_WRITE);
        return r;
    endfunction

    // io and acknowledge cycles never take memory waits
    function automatic logic no_wait_kind(input cycle_type k);
        logic r;
        r = is_io_kind(k) || (k == CYC_INT_ACK);
        return r;
    endfunction

    // register select: 0 control, 1 command, 2 status, 3 none
    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        logic [1:0] r;
        r = 2'h3;
        if (a == `CTRL_OFFSET)
            r = 2'h0;
        else if (a == `CMD_OFFSET)
            r = 2'h1;
        else if (a == `STATUS_OFFSET)
            r = 2'h2;
        return r;
    endfunction

    // --------------------------------------------------------------
    // register read mux, unmapped words read as zero
    // --------------------------------------------------------------
    function automatic logic [31:0] read_word(input logic [7:0] a, input glue_state_type v);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (reg_sel(a) == 2'h0)
            d = {14'h0000, v.remap, v.fetch_en, v.ram_ns, v.rom_ns};
        else if (reg_sel(a) == 2'h1)
            d = {5'h00, v.kind, v.wdata, v.addr};
        else if (reg_sel(a) == 2'h2)
            d = {13'h0000, v.st, v.rdata, 1'b0, v.kind, 3'h0, v.busy};
        return d;
    endfunction

    // --------------------------------------------------------------
    // read data capture point
    // --------------------------------------------------------------
    // fetches sample as the phase rises into the third state, plain
    // reads half a bus clock later, giving them the easier timing
    function automatic logic capture_now(input cycle_type k, input bus_state_type st,
        input logic half, input bus_state_type st_next);
        logic c;
        c = 1'b0;
        if (is_fetch_kind(k))
            c = half && (st == BUS_T2 || st == BUS_TW) && (st_next == BUS_T3);
        else if ((k == CYC_MEM_READ) || (k == CYC_IO_READ))
            c = (st == BUS_T3) && !half;
        return c;
    endfunction

    // waits for a launched command; ram timing covers the upper half and any remap
    function automatic logic [1:0] cmd_wait_count(input cycle_type k, input logic upper,
        input glue_state_type v);
        logic [1:0] w;
        w = (upper || v.remap) ? waits_for(v.ram_ns) : waits_for(v.rom_ns);
        if (v.fetch_en && (k != CYC_FETCH))
            w = 2'h0;
        if (no_wait_kind(k))
            w = 2'h0;
        return w;
    endfunction

    // --------------------------------------------------------------
    // state after reset: bus idle, strobes high, default access times
    // --------------------------------------------------------------
    function automatic glue_state_type reset_state();
        glue_state_type r;
        r.st = BUS_IDLE;
        r.half = 1'b0;
        r.waits_left = 2'h0;
        r.kind = CYC_FETCH;
        r.addr = 16'h0000;
        r.wdata = 8'h00;
        r.rdata = 8'h00;
        r.busy = 1'b0;
        r.rom_ns = `ROM_NS_RESET;
        r.ram_ns = `RAM_NS_RESET;
        r.fetch_en = 1'b0;
        r.remap = 1'b0;
        r.wr_pend = 1'b0;
        r.wr_sel = 8'h00;
        r.hrdata = 32'h0000_0000;
        r.system_clock_phase = 1'b1;
        r.memory_request_n_n = 1'b1;
        r.io_request_n_n = 1'b1;
        r.rd_n = 1'b1;
        r.wr_n = 1'b1;
        r.m1_n = 1'b1;
        r.data_oe = 1'b0;
        return r;
    endfunction

    logic       addr_phase;
    logic       cmd_ok;
    logic       is_mem;
    logic       is_rd;
    logic       is_wr;
    logic       is_io;
    logic       in_cyc;
    logic       t1_low;
    logic       advance;
    logic [1:0] cmd_waits;
    logic [2:0] cmd_kind;

    always_comb
    begin
        next_s = s;
        addr_phase = i_hsel && i_htrans[1] && i_hready;
        cmd_kind = i_hwdata[`CMD_KIND_LSB +: 3];
        cmd_ok = s.wr_pend && (reg_sel(s.wr_sel) == 2'h1) && !s.busy && (cmd_kind != 3'h7);
        // low half of the space is EPROM until software remaps RAM over it
        cmd_waits = cmd_wait_count(cycle_type'(cmd_kind), i_hwdata[`CMD_ADDR_LSB + 15], s);

        // ----------------------------------------------------------
        // register writes (data phase)
        // ----------------------------------------------------------
        next_s.wr_pend = 1'b0;
        if (s.wr_pend)
        begin
            if (reg_sel(s.wr_sel) == 2'h0)
            begin
                next_s.rom_ns = i_hwdata[`CTRL_ROM_NS_LSB +: 8];
                next_s.ram_ns = i_hwdata[`CTRL_RAM_NS_LSB +: 8];
                next_s.fetch_en = i_hwdata[`CTRL_FETCH_EN_BIT];
                next_s.remap = i_hwdata[`CTRL_REMAP_BIT];
            end
            else if (cmd_ok)
            begin
                next_s.busy = 1'b1;
                next_s.kind = cycle_type'(cmd_kind);
                next_s.addr = i_hwdata[`CMD_ADDR_LSB +: 16];
                next_s.wdata = i_hwdata[`CMD_DATA_LSB +: 8];
                next_s.waits_left = cmd_waits;
            end
        end

        // ----------------------------------------------------------
        // bus state sequencer, one bus state is two clock cycles
        // ----------------------------------------------------------
        next_s.half = !s.half;
        next_s.system_clock_phase = s.half;
        advance = s.half;
        if (advance)
        begin
            case (s.st)
                BUS_IDLE:
                    if (s.busy)
                        next_s.st = BUS_T1;
                BUS_T1:
                    next_s.st = BUS_T2;
                BUS_T2:
                    next_s.st = (s.waits_left != 2'h0) ? BUS_TW : BUS_T3;
                BUS_TW:
                begin
                    // each wait adds one full bus clock
                    next_s.waits_left = s.waits_left - 2'h1;
                    if (s.waits_left == 2'h1)
                        next_s.st = BUS_T3;
                end
                BUS_T3:
                begin
                    next_s.st = BUS_IDLE;
                    next_s.busy = 1'b0;
                end
                default:
                    next_s.st = BUS_IDLE;
            endcase
        end

        // ----------------------------------------------------------
        // read data capture
        // ----------------------------------------------------------
        if (capture_now(s.kind, s.st, s.half, next_s.st))
            next_s.rdata = i_data;

        // ----------------------------------------------------------
        // strobes for the coming cycle
        // ----------------------------------------------------------
        is_mem = is_mem_kind(next_s.kind);
        is_io = is_io_kind(next_s.kind);
        is_rd = is_read_kind(next_s.kind);
        is_wr = is_write_kind(next_s.kind);
        in_cyc = (next_s.st == BUS_T2) || (next_s.st == BUS_TW) || (next_s.st == BUS_T3);
        t1_low = (next_s.st == BUS_T1) && next_s.half;

        next_s.memory_request_n_n = !(is_mem && (t1_low || in_cyc));
        // io request and its strobe fall together
        next_s.io_request_n_n = !((is_io || next_s.kind == CYC_INT_ACK) && in_cyc);
        // acknowledge kind never qualifies either strobe
        next_s.rd_n = !((is_rd && (t1_low || in_cyc))
            || (next_s.kind == CYC_IO_READ && in_cyc));
        // write strobe falls a state after address and data, rises at mid third state
        next_s.wr_n = !(is_wr && ((next_s.st == BUS_T2) || (next_s.st == BUS_TW)
            || ((next_s.st == BUS_T3) && !next_s.half)));
        next_s.data_oe = is_wr && (next_s.st != BUS_IDLE);
        next_s.m1_n = !(((next_s.kind == CYC_FETCH && next_s.fetch_en)
            || next_s.kind == CYC_RET_FETCH || next_s.kind == CYC_INT_ACK)
            && (next_s.st != BUS_IDLE));

        // ----------------------------------------------------------
        // bus address phase, read data reflects any write just taken
        // ----------------------------------------------------------
        if (addr_phase)
        begin
            next_s.wr_pend = i_hwrite;
            next_s.wr_sel = i_haddr[7:0];
            if (!i_hwrite)
                next_s.hrdata = read_word(i_haddr[7:0], next_s);
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            s <= reset_state();
        end
        else
        begin
            s <= next_s;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = s.hrdata;
    assign o_system_clock_phase = s.system_clock_phase;
    assign o_addr = s.addr;
    assign o_data = s.wdata;
    assign o_data_oe = s.data_oe;
    assign o_memory_request_n = s.memory_request_n_n;
    assign o_io_request_n = s.io_request_n_n;
    assign o_read_n = s.rd_n;
    assign o_write_n = s.wr_n;
    assign o_fetch_indicator_n = s.m1_n;
    assign o_bus_state = s.st;

endmodule

// ---- verification/cpu_memory_glue_waits_monitor.sv ----
// checker of bus cycle strobe timing at the top ports
module cpu_memory_glue_waits_monitor
import glue_pkg::*;
(
    input wire logic            i_mclk,
    input wire logic            i_reset,
    input wire logic            o_system_clock_phase,
    input wire logic [15:0]     o_addr,
    input wire logic [7:0]      o_data,
    input wire logic            o_data_oe,
    input wire logic            o_memory_request_n,
    input wire logic            o_io_request_n,
    input wire logic            o_read_n,
    input wire logic            o_write_n,
    input wire logic            o_fetch_indicator_n,
    input wire glue_pkg::bus_state_type o_bus_state
);
    logic [3:0] wr_len;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // cycles the write strobe has been low so far
    always_ff @(posedge i_mclk)
        wr_len <= (i_reset || o_write_n) ? 4'h0 : wr_len + 4'h1;
    property p_intack_quiet;
        !o_io_request_n && !o_fetch_indicator_n |-> o_read_n && o_write_n;
    endproperty
    a_intack_quiet: assert property (p_intack_quiet) else $error("strobe in acknowledge");
    property p_wr_held;
        !o_write_n |-> o_data_oe && $stable(o_data) && $stable(o_addr);
    endproperty
    a_wr_held: assert property (p_wr_held) else $error("write data moved");
    property p_m1_no_write;
        !o_fetch_indicator_n |-> o_write_n;
    endproperty
    a_m1_no_write: assert property (p_m1_no_write) else $error("fetch mark on write");
    property p_wr_len;
        $rose(o_write_n) |-> wr_len[0] && wr_len >= 4'h3 && wr_len <= 4'h9;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write pulse length");
    property p_t3_len;
        $rose(o_bus_state == BUS_T3) |=> o_bus_state == BUS_T3 ##1 o_bus_state != BUS_T3;
    endproperty
    a_t3_len: assert property (p_t3_len) else $error("third state length");
    property p_state_edge;
        $changed(o_bus_state) && o_bus_state != BUS_IDLE |-> o_system_clock_phase;
    endproperty
    a_state_edge: assert property (p_state_edge) else $error("state off phase");
    property p_io_together;
        $fell(o_io_request_n) && o_fetch_indicator_n |-> !o_read_n || !o_write_n;
    endproperty
    a_io_together: assert property (p_io_together) else $error("io strobe late");
    property p_mem_io_apart;
        !o_memory_request_n |-> o_io_request_n;
    endproperty
    a_mem_io_apart: assert property (p_mem_io_apart) else $error("mem and io both");
    property p_tw_bound;
        $rose(o_bus_state == BUS_TW) |-> ##[1:6] o_bus_state == BUS_T3;
    endproperty
    a_tw_bound: assert property (p_tw_bound) else $error("too many waits");
    c_write: cover property (!o_write_n);
    c_wait: cover property (o_bus_state == BUS_TW);
    c_ack: cover property (!o_io_request_n && !o_fetch_indicator_n);
endmodule

bind cpu_memory_glue_waits cpu_memory_glue_waits_monitor mon (.i_mclk, .i_reset,
    .o_system_clock_phase, .o_addr, .o_data, .o_data_oe, .o_memory_request_n,
    .o_io_request_n, .o_read_n, .o_write_n, .o_fetch_indicator_n, .o_bus_state);

// ---- verification/mem_model.sv ----
// rom and ram chips with chip-select glue on the far side of the bus
module mem_model
(
    input  wire logic           i_mclk,
    input  wire logic [15:0]    i_addr,
    input  wire logic [7:0]     i_data,
    input  wire logic           i_memory_request_n,
    input  wire logic           i_io_request_n,
    input  wire logic           i_read_n,
    input  wire logic           i_write_n,
    output logic [7:0]          o_data,
    output logic [7:0]          o_last_wr
);
    localparam logic USER_RAM_SELECT_N = 1'b0;
    localparam logic USER_ROM_SELECT_N = 1'b0;
    logic ram_chip_select_n;
    logic rom_chip_select_n;
    logic tog = 1'b0;
    // each chip is one 32k byte half, off during io cycles
    assign ram_chip_select_n = !(i_addr[15] && !USER_RAM_SELECT_N && i_io_request_n);
    assign rom_chip_select_n = !(!i_addr[15] && !USER_ROM_SELECT_N && i_io_request_n);
    always @(posedge i_mclk)
        tog <= !tog;
    // chips answer at once, well inside the fetch-only access budget
    // undriven bus shows a changing pattern
    always_comb
        if (!i_read_n && !i_memory_request_n && !(ram_chip_select_n && rom_chip_select_n))
            o_data = i_addr[7:0] ^ (i_addr[15] ? 8'h5A : 8'hC3);
        else
            o_data = {4{tog, !tog}};
    initial o_last_wr = 8'h00;
    always @(posedge i_write_n)
        if (!ram_chip_select_n && !i_memory_request_n)
            o_last_wr <= i_data;
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the bus cycle generator
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import glue_pkg::*;
    typedef struct packed {logic [31:0] ctrl; logic [2:0] kind; logic [15:0] addr; logic [1:0] w;} row_type;
    logic i_mclk = 0, i_reset = 1, i_hsel = 0, i_hwrite = 0;
    logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, rd;
    logic [1:0] i_htrans = 0;
    logic [2:0] i_hsize = 3'h2;
    logic o_hreadyout, o_hresp, o_system_clock_phase, o_data_oe, o_memory_request_n;
    logic o_io_request_n, o_read_n, o_write_n, o_fetch_indicator_n;
    logic [15:0] o_addr;
    logic [7:0] o_data, i_data, last_wr;
    bus_state_type o_bus_state;
    int n_errors = 0, n_checks = 0, cyc = 0, tw_cnt, wr_cnt, rd_cnt, m1_cnt;
    row_type rows[11] = '{
        '{32'h000000AA, 3'h0, 16'h0100, 2'h1}, '{32'h000000C8, 3'h0, 16'h0100, 2'h2},
        '{32'h00009600, 3'h1, 16'h8010, 2'h1}, '{32'h00005500, 3'h2, 16'h8020, 2'h0},
        '{32'h000255C8, 3'h0, 16'h0000, 2'h0}, '{32'h000100C8, 3'h1, 16'h0100, 2'h0},
        '{32'h000100C8, 3'h0, 16'h0100, 2'h2}, '{32'h000000C8, 3'h3, 16'h0040, 2'h0},
        '{32'h000000C8, 3'h4, 16'h0041, 2'h0}, '{32'h000000C8, 3'h5, 16'h0000, 2'h0},
        '{32'h00000055, 3'h6, 16'h0100, 2'h0}};
    cpu_memory_glue_waits uut (.i_mclk, .i_reset, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
        .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata,
        .o_system_clock_phase, .o_addr, .o_data, .o_data_oe, .i_data, .o_memory_request_n,
        .o_io_request_n, .o_read_n, .o_write_n, .o_fetch_indicator_n, .o_bus_state);
    mem_model mem (.i_mclk, .i_addr(o_addr), .i_data(o_data), .i_memory_request_n(o_memory_request_n),
        .i_io_request_n(o_io_request_n), .i_read_n(o_read_n), .i_write_n(o_write_n),
        .o_data(i_data), .o_last_wr(last_wr));
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one single-word transfer; read data lands in rd
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_mclk);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= {24'h0, a};
        i_hwrite <= wr;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'b1) @(posedge i_mclk);
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'b1) @(posedge i_mclk);
        rd = o_hrdata;
    endtask
    task wait_idle;
        rd = 32'h1;
        for (int i = 0; i < 50 && rd[0] !== 1'b0; i++) ahb(1'b0, 8'h08, 32'h0);
        chk("busy", 32'h0, {31'h0, rd[0]});
    endtask
    task run(input row_type r);
        ahb(1'b1, 8'h00, r.ctrl);
        tw_cnt = 0;
        wr_cnt = 0;
        rd_cnt = 0;
        m1_cnt = 0;
        ahb(1'b1, 8'h04, {5'h0, r.kind, 8'hA5, r.addr});
        wait_idle();
        chk("waits", 32'(2 * r.w), 32'(tw_cnt));
        chk("write len", r.kind inside {3'h2, 3'h4} ? 32'(3 + 2 * r.w) : 32'h0, 32'(wr_cnt));
        chk("read strobe", 32'(r.kind inside {3'h0, 3'h1, 3'h3, 3'h6}), 32'(rd_cnt != 0));
        chk("fetch mark", 32'(r.kind inside {3'h5, 3'h6} || (r.kind == 3'h0 && r.ctrl[16])),
            32'(m1_cnt != 0));
        if (r.kind < 3'h2)
            chk("rdata", {24'h0, r.addr[7:0] ^ (r.addr[15] ? 8'h5A : 8'hC3)}, {24'h0, rd[15:8]});
        if (r.kind == 3'h2)
            chk("wdata", 32'hA5, {24'h0, last_wr});
    endtask
    initial forever #10 i_mclk = ~i_mclk;
    always @(posedge i_mclk)
    begin
        cyc++;
        tw_cnt += int'(o_bus_state == BUS_TW);
        wr_cnt += int'(!o_write_n);
        rd_cnt += int'(!o_read_n);
        m1_cnt += int'(!o_fetch_indicator_n);
        if (cyc == 30000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'b0;
        foreach (rows[i])
        begin
            run(rows[i]);
            $display("row %0d done", i);
        end
        ahb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 32'h0, {31'h0, o_hresp});
        ahb(1'b1, 8'h04, {5'h0, 3'h7, 8'h00, 16'h8000});
        wait_idle();
        // a second command while busy must be dropped
        ahb(1'b1, 8'h00, 32'h0000C800);
        ahb(1'b1, 8'h04, {5'h0, 3'h2, 8'h3C, 16'h8040});
        ahb(1'b1, 8'h04, {5'h0, 3'h2, 8'h11, 16'h8041});
        wait_idle();
        chk("dropped cmd", 32'h3C, {24'h0, last_wr});
        $display("refusal tests done");
        ahb(1'b1, 8'h00, 32'h00031234);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        ahb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", 32'h000096AA, rd);
        chk("strobes idle", 32'h1, {31'h0, o_read_n & o_write_n & o_memory_request_n});
        $display("reset test done");
        give_verdict();
    end
endmodule
